// >>> logic/pcg_defines.svh
// Offsets, field positions and constants of the counter group register pages
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

`define PCG_PAGE_BIT 12
`define PCG_OFF_CNT_LAST 12'h1FF
`define PCG_OFF_CNT_SMALL_LAST 12'h0FF
`define PCG_OFF_EVTYPE 12'h400
`define PCG_OFF_SHADOW 12'h600
`define PCG_OFF_SMR 12'hA00
`define PCG_OFF_CNTENSET 12'hC00
`define PCG_OFF_CNTENCLR 12'hC20
`define PCG_OFF_INTENSET 12'hC40
`define PCG_OFF_INTENCLR 12'hC60
`define PCG_OFF_OVSCLR 12'hC80
`define PCG_OFF_OVSSET 12'hCC0
`define PCG_OFF_CAPR 12'hD88
`define PCG_OFF_SCR 12'hDF8
`define PCG_OFF_CFGR 12'hE00
`define PCG_OFF_CR 12'hE04
`define PCG_OFF_IIDR 12'hE08
`define PCG_OFF_CEID0 12'hE20
`define PCG_OFF_CEID1 12'hE28
`define PCG_OFF_IRQCTRL 12'hE50
`define PCG_OFF_IRQACK 12'hE54
`define PCG_OFF_IRQCFG0 12'hE58
`define PCG_OFF_IRQCFG1 12'hE60
`define PCG_OFF_IRQCFG2 12'hE64
`define PCG_OFF_IRQSTAT 12'hE68
`define PCG_OFF_GMPAM 12'hE6C
`define PCG_OFF_AIDR 12'hE70
`define PCG_OFF_MPAMIDR 12'hE74
`define PCG_OFF_SMPAMIDR 12'hE78
`define PCG_HI_WORD 12'h004
`define PCG_ARRAY_SPAN_MASK 12'hF00
`define PCG_EVT_OVERFLOW_CAPTURE_BIT 31
`define PCG_CAPR_BIT 0
`define PCG_CFGR_NCTR_LSB 0
`define PCG_CFGR_SIZE_LSB 8
`define PCG_CFGR_RELOC_BIT 20
`define PCG_CFGR_CAPTURE_BIT 22
`define PCG_SMALL_SIZE_MAX 31
`define PCG_SMR_ANY 32'hFFFFFFFF
`define PCG_EVT_CYCLES 16'h0000

`endif

// >>> logic/pcg_pkg.sv
// Types shared by the counter group register block
package pcg_pkg;
  typedef struct packed {
    logic req;
    logic wr;
    logic [12:0] addr;
    logic [31:0] wdata;
  } pcg_bus_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } pcg_bus_rsp_t;
endpackage

// >>> logic/pcg_regs.sv
// Performance counter group: register pages, counters, overflow and capture
`include "pcg_defines.svh"

module pcg_regs #(
  parameter int unsigned NUM_COUNTERS = 64,
  parameter int unsigned SIZE_FIELD = 31,
  parameter bit RELOC_PAGE = 1'b1,
  parameter bit CAPTURE = 1'b1,
  parameter int unsigned NUM_EVENTS = 8,
  // Arbitrary identification values
  parameter logic [31:0] IIDR_VALUE = 32'h00000A5A,
  parameter logic [31:0] AIDR_VALUE = 32'h00000001,
  parameter logic [63:0] CEID0_VALUE = 64'h00000000000000FF,
  parameter logic [63:0] CEID1_VALUE = 64'h0000000000000000
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire pcg_pkg::pcg_bus_req_t bus_in,
  output pcg_pkg::pcg_bus_rsp_t bus_out,
  input wire logic [NUM_EVENTS-1:0] evt_pulse,
  input wire logic [31:0] evt_stream_id
);
  import pcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CW = SIZE_FIELD + 1;
  localparam bit WIDE = SIZE_FIELD > `PCG_SMALL_SIZE_MAX;
  localparam logic [63:0] CMASK = (64'h1 << CW) - 64'h1;
  localparam logic [63:0] IMPL = (64'h1 << NUM_COUNTERS) - 64'h1;
  localparam logic [31:0] CFGR_VALUE = (32'(NUM_COUNTERS - 1) << `PCG_CFGR_NCTR_LSB)
    | (32'(SIZE_FIELD) << `PCG_CFGR_SIZE_LSB)
    | (32'(RELOC_PAGE) << `PCG_CFGR_RELOC_BIT)
    | (32'(CAPTURE) << `PCG_CFGR_CAPTURE_BIT);

  typedef struct packed {
    logic [63:0][63:0] cnt;
    logic [63:0][63:0] shadow;
    logic [63:0][31:0] evtype;
    logic [63:0][31:0] smr;
    logic [63:0] counter_enable_bit;
    logic [63:0] inten;
    logic [63:0] ovs;
    logic [63:0] irq_cfg0;
    logic [31:0] scr;
    logic [31:0] cr;
    logic [31:0] irq_ctrl;
    logic [31:0] irq_cfg1;
    logic [31:0] irq_cfg2;
    logic [31:0] gmpam;
    logic ack;
    logic [31:0] rdata;
  } pcg_state_t;

  pcg_state_t st;
  pcg_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Slot of a counter or shadow within its array, by stride
  function automatic logic [5:0] cnt_slot(input logic [11:0] off);
    cnt_slot = WIDE ? off[8:3] : off[7:2];
  endfunction

  // Only the stride view matching the counter width decodes
  function automatic logic cnt_view_ok(input logic [11:0] off);
    cnt_view_ok = WIDE ? (off <= `PCG_OFF_CNT_LAST) : (off <= `PCG_OFF_CNT_SMALL_LAST);
  endfunction

  function automatic logic event_seen(input logic [15:0] ev, input logic [NUM_EVENTS-1:0] p);
    event_seen = 1'b0;
    for (int j = 0; j < NUM_EVENTS; j++) begin
      if (ev == 16'(j) && p[j]) begin
        event_seen = 1'b1;
      end
    end
  endfunction

  // 32-bit half of a 64-bit register, little-endian word order
  function automatic logic [31:0] half(input logic [63:0] v, input logic hi);
    half = hi ? v[63:32] : v[31:0];
  endfunction

  function automatic logic [63:0] put_half(input logic [63:0] v, input logic hi,
                                           input logic [31:0] w);
    put_half = hi ? {w, v[31:0]} : {v[63:32], w};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] off;
  logic pg1;
  logic rel_ok;
  logic base_ok;
  logic hi;
  logic [5:0] slot;
  logic [63:0] ovf;
  logic [63:0] cnt_hit;
  logic [63:0] ovs_clr;
  logic [63:0] ovs_set;
  logic cap_req;
  logic [11:0] arr_off;

  assign off = bus_in.addr[11:0];
  assign pg1 = bus_in.addr[`PCG_PAGE_BIT];
  assign rel_ok = RELOC_PAGE ? pg1 : !pg1;
  assign base_ok = !pg1;
  assign hi = WIDE && off[2];
  assign arr_off = off & ~`PCG_ARRAY_SPAN_MASK;

  always_comb begin
    next_st = st;
    next_st.ack = bus_in.req;
    next_st.rdata = '0;
    ovf = '0;
    cnt_hit = '0;
    ovs_clr = '0;
    ovs_set = '0;
    cap_req = 1'b0;
    slot = '0;

    // Event counting
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (st.counter_enable_bit[i]
          && (st.evtype[i][15:0] == `PCG_EVT_CYCLES
              || (event_seen(st.evtype[i][15:0], evt_pulse)
                  && (st.smr[i] == `PCG_SMR_ANY || st.smr[i] == evt_stream_id)))) begin
        cnt_hit[i] = 1'b1;
        next_st.cnt[i] = (st.cnt[i] + 64'h1) & CMASK;
        ovf[i] = (next_st.cnt[i] == 64'h0);
      end
    end

    // Register access
    if (bus_in.req) begin
      if (off <= `PCG_OFF_CNT_LAST) begin
        slot = cnt_slot(off);
        if (rel_ok && cnt_view_ok(off) && 32'(slot) < NUM_COUNTERS) begin
          next_st.rdata = half(st.cnt[slot], hi);
          if (bus_in.wr) begin
            // Software write replaces the addressed 32-bit half (the whole counter when narrow), dropping a same-cycle increment
            next_st.cnt[slot] = put_half(st.cnt[slot], hi, bus_in.wdata) & CMASK;
            ovf[slot] = 1'b0;
          end
        end
      end else if ((off & `PCG_ARRAY_SPAN_MASK) == `PCG_OFF_SHADOW
                   || (off & `PCG_ARRAY_SPAN_MASK) == (`PCG_OFF_SHADOW + 12'h100)) begin
        slot = cnt_slot(off - `PCG_OFF_SHADOW);
        if (CAPTURE && rel_ok && cnt_view_ok(off - `PCG_OFF_SHADOW)
            && 32'(slot) < NUM_COUNTERS) begin
          next_st.rdata = half(st.shadow[slot], hi);
        end
      end else if ((off & `PCG_ARRAY_SPAN_MASK) == `PCG_OFF_EVTYPE) begin
        slot = arr_off[7:2];
        if (base_ok && 32'(slot) < NUM_COUNTERS) begin
          next_st.rdata = st.evtype[slot];
          if (bus_in.wr) begin
            next_st.evtype[slot] = bus_in.wdata;
          end
        end
      end else if ((off & `PCG_ARRAY_SPAN_MASK) == `PCG_OFF_SMR) begin
        slot = arr_off[7:2];
        if (base_ok && 32'(slot) < NUM_COUNTERS) begin
          next_st.rdata = st.smr[slot];
          if (bus_in.wr) begin
            next_st.smr[slot] = bus_in.wdata;
          end
        end
      end else if (off[11:3] == `PCG_OFF_OVSCLR >> 3 || off[11:3] == `PCG_OFF_OVSSET >> 3
                   || off == `PCG_OFF_CAPR) begin
        if (rel_ok) begin
          if (off == `PCG_OFF_CAPR) begin
            cap_req = bus_in.wr && bus_in.wdata[`PCG_CAPR_BIT];
          end else begin
            next_st.rdata = half(st.ovs, off[2]);
            if (bus_in.wr && off[11:3] == `PCG_OFF_OVSCLR >> 3) begin
              ovs_clr = put_half(64'h0, off[2], bus_in.wdata) & IMPL;
            end else if (bus_in.wr) begin
              ovs_set = put_half(64'h0, off[2], bus_in.wdata) & IMPL;
            end
          end
        end
      end else if (base_ok) begin
        unique case ({off[11:3], 3'b000})
          `PCG_OFF_CNTENSET, `PCG_OFF_CNTENCLR: begin
            next_st.rdata = half(st.counter_enable_bit, off[2]);
            if (bus_in.wr && off[11:3] == `PCG_OFF_CNTENSET >> 3) begin
              next_st.counter_enable_bit = st.counter_enable_bit | (put_half(64'h0, off[2], bus_in.wdata) & IMPL);
            end else if (bus_in.wr) begin
              next_st.counter_enable_bit = st.counter_enable_bit & ~put_half(64'h0, off[2], bus_in.wdata);
            end
          end
          `PCG_OFF_INTENSET, `PCG_OFF_INTENCLR: begin
            next_st.rdata = half(st.inten, off[2]);
            if (bus_in.wr && off[11:3] == `PCG_OFF_INTENSET >> 3) begin
              next_st.inten = st.inten | (put_half(64'h0, off[2], bus_in.wdata) & IMPL);
            end else if (bus_in.wr) begin
              next_st.inten = st.inten & ~put_half(64'h0, off[2], bus_in.wdata);
            end
          end
          `PCG_OFF_CEID0: begin
            next_st.rdata = half(CEID0_VALUE, off[2]);
          end
          `PCG_OFF_CEID1: begin
            next_st.rdata = half(CEID1_VALUE, off[2]);
          end
          `PCG_OFF_IRQCFG0: begin
            next_st.rdata = half(st.irq_cfg0, off[2]);
            if (bus_in.wr) begin
              next_st.irq_cfg0 = put_half(st.irq_cfg0, off[2], bus_in.wdata);
            end
          end
          default: begin
            // 32-bit registers; read-only ones ignore writes
            unique case (off)
              `PCG_OFF_SCR: begin
                next_st.rdata = st.scr;
                if (bus_in.wr) next_st.scr = bus_in.wdata;
              end
              `PCG_OFF_CR: begin
                next_st.rdata = st.cr;
                if (bus_in.wr) next_st.cr = bus_in.wdata;
              end
              `PCG_OFF_IRQCTRL: begin
                next_st.rdata = st.irq_ctrl;
                if (bus_in.wr) next_st.irq_ctrl = bus_in.wdata;
              end
              `PCG_OFF_IRQCFG1: begin
                next_st.rdata = st.irq_cfg1;
                if (bus_in.wr) next_st.irq_cfg1 = bus_in.wdata;
              end
              `PCG_OFF_IRQCFG2: begin
                next_st.rdata = st.irq_cfg2;
                if (bus_in.wr) next_st.irq_cfg2 = bus_in.wdata;
              end
              `PCG_OFF_GMPAM: begin
                next_st.rdata = st.gmpam;
                if (bus_in.wr) next_st.gmpam = bus_in.wdata;
              end
              `PCG_OFF_CFGR: next_st.rdata = CFGR_VALUE;
              `PCG_OFF_IIDR: next_st.rdata = IIDR_VALUE;
              `PCG_OFF_AIDR: next_st.rdata = AIDR_VALUE;
              `PCG_OFF_IRQACK: next_st.rdata = st.irq_ctrl;
              default: next_st.rdata = '0;
            endcase
          end
        endcase
      end
    end

    // Set beats clear on the sticky overflow bits
    next_st.ovs = (st.ovs & ~ovs_clr) | ovs_set | (ovf & IMPL);

    // Capture samples the counters as they stand at this edge
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (ovf[i] && st.evtype[i][`PCG_EVT_OVERFLOW_CAPTURE_BIT] && CAPTURE) begin
        cap_req = 1'b1;
      end
    end
    if (cap_req && CAPTURE) begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        next_st.shadow[i] = st.cnt[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bus_out.ack = st.ack;
  assign bus_out.rdata = st.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic wr_cnt0;
  logic clr_ovs0;
  // Either half of counter 0, so wide counters do not trip the hold check
  assign wr_cnt0 = bus_in.req && bus_in.wr && off <= `PCG_OFF_CNT_LAST && cnt_view_ok(off)
                   && cnt_slot(off) == 6'h00 && rel_ok;
  assign clr_ovs0 = bus_in.req && bus_in.wr && off == `PCG_OFF_OVSCLR && rel_ok
                    && bus_in.wdata[0];

  property p_ack;
    @(posedge core_clk) disable iff (sys_rst)
      bus_in.req |=> bus_out.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered");

  property p_no_ack;
    @(posedge core_clk) disable iff (sys_rst)
      !bus_in.req |=> !bus_out.ack && bus_out.rdata == 32'h00000000;
  endproperty
  a_no_ack: assert property (p_no_ack) else $error("answer without request");

  property p_width;
    @(posedge core_clk) disable iff (sys_rst)
      (st.cnt[0] & ~CMASK) == 64'h0;
  endproperty
  a_width: assert property (p_width) else $error("counter above width");

  property p_unimpl;
    @(posedge core_clk) disable iff (sys_rst)
      NUM_COUNTERS < 64 |-> st.cnt[63] == 64'h0 && !st.counter_enable_bit[63];
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("absent counter holds state");

  property p_inc;
    @(posedge core_clk) disable iff (sys_rst)
      cnt_hit[0] && !wr_cnt0 |=> st.cnt[0] == (($past(st.cnt[0]) + 64'h1) & CMASK);
  endproperty
  a_inc: assert property (p_inc) else $error("counter did not increment");

  property p_hold;
    @(posedge core_clk) disable iff (sys_rst)
      !st.counter_enable_bit[0] && !wr_cnt0 |=> $stable(st.cnt[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("disabled counter moved");

  property p_atomic;
    @(posedge core_clk) disable iff (sys_rst)
      wr_cnt0 |=> half(st.cnt[0], $past(hi)) == ($past(bus_in.wdata) & half(CMASK, $past(hi)));
  endproperty
  a_atomic: assert property (p_atomic) else $error("write merged with increment");

  property p_ovs_set;
    @(posedge core_clk) disable iff (sys_rst)
      ovf[0] |=> st.ovs[0];
  endproperty
  a_ovs_set: assert property (p_ovs_set) else $error("overflow not flagged");

  property p_ovs_sticky;
    @(posedge core_clk) disable iff (sys_rst)
      st.ovs[0] && !clr_ovs0 |=> st.ovs[0];
  endproperty
  a_ovs_sticky: assert property (p_ovs_sticky) else $error("overflow flag lost");

  property p_capture;
    @(posedge core_clk) disable iff (sys_rst)
      cap_req && CAPTURE |=> st.shadow[0] == $past(st.cnt[0]);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");

  property p_reloc_zero;
    @(posedge core_clk) disable iff (sys_rst)
      bus_in.req && RELOC_PAGE && !pg1 && off <= `PCG_OFF_CNT_LAST
        |=> bus_out.rdata == 32'h00000000;
  endproperty
  a_reloc_zero: assert property (p_reloc_zero) else $error("base page counter visible");

  property p_no_capture;
    @(posedge core_clk) disable iff (sys_rst)
      !cap_req |=> $stable(st.shadow[0]);
  endproperty
  a_no_capture: assert property (p_no_capture) else $error("shadow moved");

  property p_page1_plain;
    @(posedge core_clk) disable iff (sys_rst)
      bus_in.req && pg1 && off[11:8] == 4'hE |=> bus_out.rdata == 32'h00000000;
  endproperty
  a_page1_plain: assert property (p_page1_plain) else $error("page copy visible");

  property p_stride_view;
    @(posedge core_clk) disable iff (sys_rst)
      bus_in.req && !WIDE && off[11:8] == 4'h1 |=> bus_out.rdata == 32'h00000000;
  endproperty
  a_stride_view: assert property (p_stride_view) else $error("unused view visible");

  property p_absent_read;
    @(posedge core_clk) disable iff (sys_rst)
      bus_in.req && off <= `PCG_OFF_CNT_LAST && 32'(cnt_slot(off)) >= NUM_COUNTERS
        |=> bus_out.rdata == 32'h00000000;
  endproperty
  a_absent_read: assert property (p_absent_read) else $error("absent counter visible");

  c_overflow: cover property (@(posedge core_clk) disable iff (sys_rst) ovf[0]);
  c_capture: cover property (@(posedge core_clk) disable iff (sys_rst) cap_req);
  c_write_inc: cover property (@(posedge core_clk) disable iff (sys_rst)
    wr_cnt0 && cnt_hit[0]);
  c_read: cover property (@(posedge core_clk) disable iff (sys_rst)
    bus_in.req && !bus_in.wr && off == 12'h000 ##1 bus_out.rdata != 32'h00000000);
endmodule

// >>> testbench/test_pcg_regs.sv
// Self-checking bench for the counter group register block
module test_pcg_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import pcg_pkg::*;

  typedef struct packed {
    logic w;
    logic [12:0] a;
    logic [31:0] d;
  } pcg_row_t;

  logic core_clk;
  logic sys_rst;
  pcg_bus_req_t bus_in;
  pcg_bus_rsp_t bus_out;
  pcg_bus_rsp_t bus_out_w;
  logic [7:0] evt_pulse;
  logic [31:0] evt_stream_id;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;

  // Small counters so a wrap takes one write and one event
  pcg_regs #(.NUM_COUNTERS(4), .SIZE_FIELD(7)) pcg_regs_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .bus_in(bus_in),
    .bus_out(bus_out),
    .evt_pulse(evt_pulse),
    .evt_stream_id(evt_stream_id)
  );

  // Wide counters, no second page and no capture; shares the request bus
  pcg_regs #(.NUM_COUNTERS(4), .SIZE_FIELD(39), .RELOC_PAGE(1'b0), .CAPTURE(1'b0))
    pcg_regs_wide_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .bus_in(bus_in),
    .bus_out(bus_out_w),
    .evt_pulse(evt_pulse),
    .evt_stream_id(evt_stream_id)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One access; events may ride along on the same taking edge
  task automatic bus_op(input logic w, input logic [12:0] a, input logic [31:0] d,
                        input logic [7:0] ev, output logic [31:0] r);
    @(posedge core_clk);
    bus_in <= '{req: 1'b1, wr: w, addr: a, wdata: d};
    evt_pulse <= ev;
    @(posedge core_clk);
    bus_in.req <= 1'b0;
    evt_pulse <= 8'h00;
    #1;
    check("ack", 32'h00000001, {31'h00000000, bus_out.ack});
    r = bus_out.rdata;
  endtask

  task automatic wr_reg(input logic [12:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus_op(1'b1, a, d, 8'h00, r);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus_op(1'b0, a, 32'h00000000, 8'h00, r);
    check($sformatf("rdata@%h", a), exp, r);
  endtask

  // Same access, answer taken from the wide instance while it stands
  task automatic rdw_chk(input logic [12:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus_op(1'b0, a, 32'h00000000, 8'h00, r);
    check($sformatf("wide_rdata@%h", a), exp, bus_out_w.rdata);
  endtask

  // Counted at the second edge
  task automatic pulse(input logic [7:0] ev, input logic [31:0] sid);
    @(posedge core_clk);
    evt_pulse <= ev;
    evt_stream_id <= sid;
    @(posedge core_clk);
    evt_pulse <= 8'h00;
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  pcg_row_t rows [31] = '{
    '{1'b0, 13'h1000, 32'h00000000},
    '{1'b1, 13'h0400, 32'h00000001},
    '{1'b1, 13'h0404, 32'h00000007},
    '{1'b0, 13'h0400, 32'h00000001},
    '{1'b1, 13'h0A00, 32'hFFFFFFFF},
    '{1'b0, 13'h0A00, 32'hFFFFFFFF},
    '{1'b0, 13'h1400, 32'h00000000},
    '{1'b0, 13'h0E00, 32'h00500703},
    '{1'b1, 13'h0E00, 32'h00000000},
    '{1'b0, 13'h0E00, 32'h00500703},
    '{1'b1, 13'h0000, 32'h00000055},
    '{1'b0, 13'h1000, 32'h00000000},
    '{1'b0, 13'h0000, 32'h00000000},
    '{1'b1, 13'h1000, 32'h000001FF},
    '{1'b0, 13'h1000, 32'h000000FF},
    '{1'b1, 13'h1014, 32'h00000012},
    '{1'b0, 13'h1014, 32'h00000000},
    '{1'b0, 13'h1100, 32'h00000000},
    '{1'b1, 13'h1600, 32'h00000033},
    '{1'b0, 13'h1600, 32'h00000000},
    '{1'b1, 13'h0C00, 32'h00000003},
    '{1'b0, 13'h0C20, 32'h00000003},
    '{1'b1, 13'h0C20, 32'h00000002},
    '{1'b0, 13'h0C00, 32'h00000001},
    '{1'b1, 13'h0C40, 32'h0000000F},
    '{1'b1, 13'h0C60, 32'h00000005},
    '{1'b0, 13'h0C40, 32'h0000000A},
    '{1'b0, 13'h1D88, 32'h00000000},
    '{1'b0, 13'h0F00, 32'h00000000},
    '{1'b0, 13'h0E08, 32'h00000A5A},
    '{1'b0, 13'h0C24, 32'h00000000}
  };

  initial begin
    sys_rst = 1'b1;
    bus_in = '0;
    evt_pulse = 8'h00;
    evt_stream_id = 32'h00000000;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr_reg(rows[i].a, rows[i].d);
      end else begin
        rd_chk(rows[i].a, rows[i].d);
      end
    end
    // Exact stream filter, wrap and sticky overflow
    wr_reg(13'h0A00, 32'h00000042);
    pulse(8'h02, 32'h00000042);
    rd_chk(13'h1000, 32'h00000000);
    rd_chk(13'h1C80, 32'h00000001);
    rd_chk(13'h0C80, 32'h00000000);
    rd_chk(13'h1600, 32'h00000000);
    pulse(8'h02, 32'h00000043);
    rd_chk(13'h1000, 32'h00000000);
    pulse(8'h80, 32'h00000042);
    rd_chk(13'h1004, 32'h00000000);
    pulse(8'h02, 32'h00000042);
    rd_chk(13'h1000, 32'h00000001);
    rd_chk(13'h1CC0, 32'h00000001);
    wr_reg(13'h1C80, 32'h00000001);
    rd_chk(13'h1CC0, 32'h00000000);
    wr_reg(13'h1CC0, 32'h00000002);
    rd_chk(13'h1C80, 32'h00000002);
    wr_reg(13'h1C80, 32'h00000002);
    // Overflow capture takes pre-increment values of all counters
    wr_reg(13'h1000, 32'h000000FF);
    wr_reg(13'h1008, 32'h00000021);
    wr_reg(13'h0400, 32'h80000001);
    pulse(8'h02, 32'h00000042);
    rd_chk(13'h1600, 32'h000000FF);
    rd_chk(13'h1608, 32'h00000021);
    wr_reg(13'h1008, 32'h00000044);
    wr_reg(13'h1D88, 32'h00000001);
    rd_chk(13'h1608, 32'h00000044);
    rd_chk(13'h1600, 32'h00000000);
    // Software write and increment on one edge: the write wins whole
    wr_reg(13'h0A00, 32'hFFFFFFFF);
    bus_op(1'b1, 13'h1000, 32'h000001AB, 8'h02, rd);
    rd_chk(13'h1000, 32'h000000AB);
    // Wide counters: 8-byte stride, little-endian halves, base page only
    wr_reg(13'h0008, 32'h12345678);
    wr_reg(13'h000C, 32'hFFFFFF9A);
    wr_reg(13'h0D88, 32'h00000001);
    rdw_chk(13'h0008, 32'h12345678);
    rdw_chk(13'h000C, 32'h0000009A);
    rd_chk(13'h0008, 32'h00000000);
    rdw_chk(13'h1008, 32'h00000000);
    rdw_chk(13'h0608, 32'h00000000);
    rdw_chk(13'h0E00, 32'h00002703);
    // Second reset in mid-run, with a read standing through it
    @(posedge core_clk);
    sys_rst <= 1'b1;
    bus_in <= '{req: 1'b1, wr: 1'b0, addr: 13'h1000, wdata: 32'h00000000};
    repeat (2) @(posedge core_clk);
    #1;
    check("ack_in_reset", 32'h00000000, {31'h00000000, bus_out.ack});
    check("rdata_in_reset", 32'h00000000, bus_out.rdata);
    @(posedge core_clk);
    bus_in.req <= 1'b0;
    @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_chk(13'h1000, 32'h00000000);
    rd_chk(13'h0C00, 32'h00000000);
    rd_chk(13'h0400, 32'h00000000);
    tally_and_finish();
  end
endmodule
